// ==== hdl/audio_fifo_status_flags.sv ====
// Purpose: FIFO level flags, receive data ports and interrupt clear logic
// Assumes: Levels and data come from logic on SYS_CLK; Avalon-MM slave
// Notes:   One wait state on every access; reads answer with waitrequest low
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
module audio_fifo_status_flags #(
  parameter int unsigned NUM_FIFO = 4         // FIFO pairs
) (
  input  wire logic        SYS_CLK,           // System clock, 250 MHz
  input  wire logic        RST_N,             // Combined reset, active low
  input  wire logic [11:0] AVS_ADDRESS,       // Byte address
  input  wire logic        AVS_READ,          // Read request
  input  wire logic        AVS_WRITE,         // Write request
  input  wire logic [31:0] AVS_WRITEDATA,     // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE,    // Byte lanes
  output logic      [31:0] AVS_READDATA,      // Read data
  output logic             AVS_WAITREQUEST,   // Stall
  output logic      [1:0]  AVS_RESPONSE,      // 00 ok, 10 slave error
  input  wire logic [11:0] FIFO_LEVELS,       // Four 3-bit counts, tx in 2:0
  input  wire logic [95:0] RX_WORDS,          // Ch5 in 31:0, ch6, ch7
  input  wire logic [2:0]  RX_WORD_VALID,     // Word strobes ch5..ch7
  output logic      [2:0]  RX_WORD_POP,       // Pulse when a port is read
  output logic             IRQ                // Level interrupt
);
  logic [31:0] flags_r;        // Registered level flag word
  logic [31:0] flags_nxt;      // Next flag word
  logic [31:0] pend_r;         // Pending interrupts per flag bit
  logic [31:0] evt_r;          // Sticky pair events
  logic [31:0] mask_r;         // Interrupt mask
  logic [31:0] rdata_r;        // Read data register
  logic [1:0]  resp_r;         // Response register
  logic        ack_r;          // Access answered this cycle
  logic        req;            // Request present
  logic        wr_go;          // Write taking effect
  logic        rd_go;          // Read taking effect
  logic [31:0] wmask;          // Byte-lane write mask
  logic [31:0] rise;           // Flag bits that just rose
  logic [31:0] pair_done;      // Pairs whose both bits are clear
  rx_data_if   dif ();         // Receive word carrier

  // Flag decode of one 3-bit level: {af, hf, ae}
  function automatic logic [2:0] level_flags(input logic [2:0] lvl);
    level_flags[2] = (lvl >= fifo_flags_pkg::LVL_AF_MIN);
    level_flags[1] = (lvl == fifo_flags_pkg::LVL_HF);
    level_flags[0] = (lvl <= fifo_flags_pkg::LVL_AE_MAX);
  endfunction

  // Both bits of pair p in a word, for bit group lsb
  function automatic logic [31:0] pair_bits(input int unsigned lsb, input int unsigned p);
    pair_bits = 32'h00000000;
    pair_bits[lsb + 7 - 2*p] = 1'b1;
    pair_bits[lsb + 6 - 2*p] = 1'b1;
  endfunction

  assign dif.in_data[0] = RX_WORDS[31:0];
  assign dif.in_data[1] = RX_WORDS[63:32];
  assign dif.in_data[2] = RX_WORDS[95:64];
  assign dif.in_valid   = RX_WORD_VALID;

  rx_data_hold u_hold (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .dif   (dif)
  );

  // Build the flag word: one decode per FIFO, copied to both channel bits
  always_comb begin
    logic [2:0] f;
    f = 3'h0;
    flags_nxt = fifo_flags_pkg::ZERO_WORD;
    for (int p = 0; p < NUM_FIFO; p++) begin
      f = level_flags(FIFO_LEVELS[3*p +: 3]);
      flags_nxt[fifo_flags_pkg::AF_LSB + 7 - 2*p] = f[2];
      flags_nxt[fifo_flags_pkg::AF_LSB + 6 - 2*p] = f[2];
      flags_nxt[fifo_flags_pkg::HF_LSB + 7 - 2*p] = f[1];
      flags_nxt[fifo_flags_pkg::HF_LSB + 6 - 2*p] = f[1];
      flags_nxt[fifo_flags_pkg::AE_LSB + 7 - 2*p] = f[0];
      flags_nxt[fifo_flags_pkg::AE_LSB + 6 - 2*p] = f[0];
    end
  end

  // Both channel bits come from one flop input, so they change together
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_r <= fifo_flags_pkg::ZERO_WORD;
    end else begin
      flags_r <= flags_nxt & fifo_flags_pkg::RESV_MASK;
    end
  end

  // Bus decode; answer comes one cycle after the request is seen
  assign req             = (AVS_READ | AVS_WRITE) & ~ack_r;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
  // A write lands only at the edge where waitrequest is sampled low
  assign wr_go           = AVS_WRITE & ack_r;
  assign rd_go           = AVS_READ & ~ack_r;
  assign AVS_READDATA    = rdata_r;
  assign AVS_RESPONSE    = resp_r;
  assign rise            = flags_nxt & ~flags_r & fifo_flags_pkg::RESV_MASK;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{AVS_BYTEENABLE[b]}};
    end
  end

  // Ack toggles high for the answer cycle only
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data and response are captured in the request cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= fifo_flags_pkg::ZERO_WORD;
      resp_r  <= 2'h0;
    end else if (req) begin
      resp_r  <= 2'h0;
      rdata_r <= fifo_flags_pkg::ZERO_WORD;
      unique case (AVS_ADDRESS)
        fifo_flags_pkg::OFS_RX_CH5:      rdata_r <= dif.held[0];
        fifo_flags_pkg::OFS_RX_CH6:      rdata_r <= dif.held[1];
        fifo_flags_pkg::OFS_RX_CH7:      rdata_r <= dif.held[2];
        fifo_flags_pkg::OFS_LEVEL_FLAGS: rdata_r <= flags_r;
        fifo_flags_pkg::OFS_IRQ_ACK:     rdata_r <= pend_r;
        fifo_flags_pkg::OFS_IRQ_MASK:    rdata_r <= mask_r;
        fifo_flags_pkg::OFS_EVT_STATUS:  rdata_r <= evt_r;
        default: begin
          resp_r <= 2'h2;                                  // Unmapped: slave error
        end
      endcase
    end
  end

  // Pop a data port when it is read, so the source may advance
  always_comb begin
    RX_WORD_POP    = 3'h0;
    RX_WORD_POP[0] = rd_go & (AVS_ADDRESS == fifo_flags_pkg::OFS_RX_CH5);
    RX_WORD_POP[1] = rd_go & (AVS_ADDRESS == fifo_flags_pkg::OFS_RX_CH6);
    RX_WORD_POP[2] = rd_go & (AVS_ADDRESS == fifo_flags_pkg::OFS_RX_CH7);
  end

  // Pending interrupts: set on a rising flag, cleared by writing one
  // A rise in the same cycle as the clear wins, so no event is lost
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_r <= fifo_flags_pkg::ZERO_WORD;
    end else if (wr_go && AVS_ADDRESS == fifo_flags_pkg::OFS_IRQ_ACK) begin
      pend_r <= (pend_r & ~(AVS_WRITEDATA & wmask & fifo_flags_pkg::RESV_MASK)) | rise;
    end else begin
      pend_r <= pend_r | rise;
    end
  end

  // A pair counts as cleared only once both its channel bits are clear
  always_comb begin
    pair_done = fifo_flags_pkg::ZERO_WORD;
    for (int p = 0; p < NUM_FIFO; p++) begin
      for (int g = 0; g < 3; g++) begin
        if ((pend_r & pair_bits(fifo_flags_pkg::AE_LSB + 8*g, p)) == 32'h00000000) begin
          pair_done = pair_done | pair_bits(fifo_flags_pkg::AE_LSB + 8*g, p);
        end
      end
    end
  end

  // Mask register, software-written; steers the interrupt output
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_r <= fifo_flags_pkg::ZERO_WORD;
    end else if (wr_go && AVS_ADDRESS == fifo_flags_pkg::OFS_IRQ_MASK) begin
      mask_r <= ((mask_r & ~wmask) | (AVS_WRITEDATA & wmask)) & fifo_flags_pkg::RESV_MASK;
    end
  end

  // Sticky event bits set on each rising flag, as pending bits are; a read of this word clears them
  // New events in the reading cycle survive the clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_r <= fifo_flags_pkg::ZERO_WORD;
    end else if (rd_go && AVS_ADDRESS == fifo_flags_pkg::OFS_EVT_STATUS) begin
      evt_r <= rise;
    end else begin
      evt_r <= evt_r | rise;
    end
  end

  // Interrupt stays up until every pending pair is wholly cleared and events are read
  assign IRQ = |((evt_r | (pend_r & ~pair_done)) & mask_r);
endmodule

// ==== hdl/fifo_flags_pkg.sv ====
// Purpose: Shared constants for the audio FIFO status and interrupt block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   Offsets are byte addresses of aligned words
package fifo_flags_pkg;
  localparam int unsigned ADDR_W             = 12;                  // Byte address width
  localparam int unsigned DATA_W             = 32;                  // Bus data width
  localparam int unsigned LEVEL_W            = 3;                   // Sample count 0..4
  localparam int unsigned NUM_FIFO           = 4;                   // Transmit plus three receive
  localparam int unsigned NUM_RXCH           = 3;                   // PCM receive channels 5..7
  localparam logic [11:0] OFS_RX_CH5         = 12'h044;             // PCM receive ch5 data
  localparam logic [11:0] OFS_RX_CH6         = 12'h048;             // PCM receive ch6 data
  localparam logic [11:0] OFS_RX_CH7         = 12'h04C;             // PCM receive ch7 data
  localparam logic [11:0] OFS_LEVEL_FLAGS    = 12'h050;             // Level flag word
  localparam logic [11:0] OFS_IRQ_ACK        = 12'h054;             // Interrupt acknowledge
  localparam logic [11:0] OFS_IRQ_MASK       = 12'h06C;             // Interrupt mask
  localparam logic [11:0] OFS_EVT_STATUS     = 12'h070;             // Sticky events, read clears
  localparam int unsigned AF_LSB             = 24;                  // Almost-full group low bit
  localparam int unsigned HF_LSB             = 16;                  // Half-full group low bit
  localparam int unsigned AE_LSB             = 8;                   // Almost-empty group low bit
  localparam logic [2:0]  LVL_AF_MIN         = 3'h3;                // Almost full from three
  localparam logic [2:0]  LVL_HF             = 3'h2;                // Half full at exactly two
  localparam logic [2:0]  LVL_AE_MAX         = 3'h1;                // Almost empty up to one
  localparam logic [31:0] RESV_MASK          = 32'hFFFFFF00;        // Bits 7:0 reserved
  localparam logic [31:0] ZERO_WORD          = 32'h00000000;        // Reset and reserved value
endpackage

// ==== hdl/rx_data_hold.sv ====
// Purpose: Holds latest word of each PCM receive channel 5..7
// Assumes: Strobes come from logic on SYS_CLK
// Notes:   Read data come out of flip-flops
`timescale 1ns/100ps
module rx_data_hold (
  input  wire logic clk,            // System clock
  input  wire logic rst_n,          // Async reset, active low
  rx_data_if.holder dif             // Channel words
);
  // Capture each channel word on its strobe; zero after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        dif.held[i] <= fifo_flags_pkg::ZERO_WORD;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (dif.in_valid[i]) begin
          dif.held[i] <= dif.in_data[i];
        end
      end
    end
  end
endmodule

// ==== hdl/rx_data_if.sv ====
// Purpose: Carries receive channel data words between top and data holder
// Assumes: One clock domain
// Notes:   Pop pulses go to the sample source through the top
`timescale 1ns/100ps
interface rx_data_if;
  logic [2:0][31:0] in_data;   // Incoming channel words
  logic [2:0]       in_valid;  // Word strobes
  logic [2:0][31:0] held;      // Registered words
  modport top    (output in_data, output in_valid, input held);
  modport holder (input in_data, input in_valid, output held);
endinterface

// ==== tb/audio_fifo_status_flags_properties.sv ====
// Purpose: Port properties of the FIFO flag block
// Assumes: Levels held steady around flag reads
// Notes:   Bound to the top module
`timescale 1ns/100ps
module audio_fifo_status_flags_properties #(
  parameter int unsigned NUM_FIFO = 4          // FIFO pairs
) (
  input wire logic        SYS_CLK,             // Clock
  input wire logic        RST_N,               // Reset, active low
  input wire logic [11:0] AVS_ADDRESS,         // Address
  input wire logic        AVS_READ,            // Read
  input wire logic        AVS_WRITE,           // Write
  input wire logic [31:0] AVS_READDATA,        // Read data
  input wire logic        AVS_WAITREQUEST,     // Stall
  input wire logic [11:0] FIFO_LEVELS,         // Counts
  input wire logic [2:0]  RX_WORD_POP,         // Pops
  input wire logic        IRQ                  // Interrupt
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Flag read answer; levels steady so the two-edge flag lag cannot matter
  sequence s_flag_rd;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 12'h050 &&
      $stable(FIFO_LEVELS) && $past(FIFO_LEVELS, 2) == FIFO_LEVELS;
  endsequence
  // One wait state, then the answer
  sequence s_answer;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  property p_af; s_flag_rd |-> AVS_READDATA[31:30] == {2{FIFO_LEVELS[2:0] >= 3'h3}}; endproperty
  property p_hf; s_flag_rd |-> AVS_READDATA[21:20] == {2{FIFO_LEVELS[5:3] == 3'h2}}; endproperty
  property p_ae; s_flag_rd |-> AVS_READDATA[9:8] == {2{FIFO_LEVELS[11:9] <= 3'h1}}; endproperty
  property p_pair; s_flag_rd |-> ((AVS_READDATA[31:8] >> 1) & 24'h555555) == (AVS_READDATA[31:8] & 24'h555555);
  endproperty
  property p_resv; s_flag_rd |-> AVS_READDATA[7:0] == 8'h00; endproperty
  property p_pop; AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 12'h04C |-> RX_WORD_POP == 3'h4; endproperty
  property p_rst; $rose(RST_N) |-> AVS_READDATA == 32'h0 && !IRQ && RX_WORD_POP == 3'h0; endproperty
  property p_wait; $rose(AVS_READ || AVS_WRITE) |-> s_answer; endproperty
  a_af: assert property (p_af) else $error("almost full flag wrong");
  a_hf: assert property (p_hf) else $error("half full flag wrong");
  a_ae: assert property (p_ae) else $error("almost empty flag wrong");
  a_pair: assert property (p_pair) else $error("channel flags differ");
  a_resv: assert property (p_resv) else $error("reserved bits set");
  a_pop: assert property (p_pop) else $error("pop missing");
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  a_wait: assert property (p_wait) else $error("wait state wrong");
endmodule
bind audio_fifo_status_flags audio_fifo_status_flags_properties #(.NUM_FIFO(NUM_FIFO)) chk_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FIFO_LEVELS(FIFO_LEVELS),
  .RX_WORD_POP(RX_WORD_POP), .IRQ(IRQ));

// ==== tb/test_audio_fifo_status_flags.sv ====
// Purpose: Register bench for the FIFO flag block
// Assumes: Mask bit one lets a source through
// Notes:   Bus task holds the request until waitrequest is low
`timescale 1ns/100ps
module test_audio_fifo_status_flags;
  logic        clk = 1'b0;           // Clock
  logic        rst_n = 1'b0;         // Reset, active low
  logic [11:0] addr = 12'h000;       // Address
  logic        rd = 1'b0;            // Read
  logic        wr = 1'b0;            // Write
  logic [31:0] wdata = 32'h0;        // Write data
  logic [11:0] levels = 12'h000;     // FIFO counts
  logic [11:0] lv;                   // Next counts
  logic [95:0] words = 96'h0;        // Channel words
  logic [2:0]  wvalid = 3'h0;        // Word strobes
  logic [31:0] rdata, got, acc;      // Read data, taken value, flags seen
  logic [1:0]  resp, rsp;            // Response, taken response
  logic        waitreq, irq;         // Stall, interrupt
  int          error_cnt = 0;        // Mismatches
  int          n_compared = 0;       // Comparisons
  audio_fifo_status_flags audio_fifo_status_flags_inst (
    .SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .AVS_RESPONSE(resp), .FIFO_LEVELS(levels), .RX_WORDS(words), .RX_WORD_VALID(wvalid),
    .RX_WORD_POP(), .IRQ(irq));
  // Free-running 250 MHz clock
  initial forever #2 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One access; answer taken at the edge where waitrequest is low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d;
    do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 50);
    got = rdata; rsp = resp;
    if (n >= 50) check("waitrequest", {31'h0, waitreq}, 32'h0);
    rd <= 1'b0; wr <= 1'b0;
  endtask
  // Expected flag word for four counts
  function automatic logic [31:0] flags(input logic [11:0] v);
    logic [2:0] l;
    flags = 32'h0;
    for (int f = 0; f < 4; f++) begin
      l = v[3*f +: 3];
      flags[31-2*f -: 2] = {2{l >= 3'h3}};
      flags[23-2*f -: 2] = {2{l == 3'h2}};
      flags[15-2*f -: 2] = {2{l <= 3'h1}};
    end
  endfunction
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles the tests take
  initial begin
    #40000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      bus(1'b0, 12'h044 + 12'(4*c), 32'h0);
      check("data port reset", got, 32'h0);
    end
    $display("reset test done");
    acc = 32'h0;
    // Each FIFO walks through every count 0..4
    for (int s = 0; s < 5; s++) begin
      for (int f = 0; f < 4; f++) lv[3*f +: 3] = 3'((s + f) % 5);
      levels <= lv;
      repeat (2) @(posedge clk);
      bus(1'b0, 12'h050, 32'h0);
      check("level flags", got, flags(lv));
      acc = acc | flags(lv);
    end
    $display("flag test done");
    @(posedge clk);
    words <= {32'hC7C70007, 32'hC6C60006, 32'hC5C50005}; wvalid <= 3'h7;
    @(posedge clk);
    wvalid <= 3'h0;
    bus(1'b1, 12'h048, 32'hFFFFFFFF);
    for (int c = 0; c < 3; c++) begin
      bus(1'b0, 12'h044 + 12'(4*c), 32'h0);
      check("data port", got, 32'hC5C50005 + 32'h01010001 * c);
    end
    bus(1'b0, 12'h100, 32'h0);
    check("unmapped response", {30'h0, rsp}, 32'h2);
    check("unmapped data", got, 32'h0);
    $display("data test done");
    bus(1'b0, 12'h054, 32'h0);
    check("pending", got, acc);
    bus(1'b0, 12'h070, 32'h0);
    bus(1'b0, 12'h070, 32'h0);
    check("events cleared by read", got, 32'h0);
    bus(1'b1, 12'h06C, 32'h0);
    @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, 12'h06C, 32'hFFFFFFFF);
    @(posedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    bus(1'b1, 12'h054, 32'hAAAAAAFF);
    bus(1'b0, 12'h054, 32'h0);
    check("pending ch0 cleared", got, acc & 32'h55555500);
    check("irq pair held", {31'h0, irq}, 32'h1);
    bus(1'b1, 12'h054, 32'h0);
    bus(1'b0, 12'h054, 32'h0);
    check("pending zero write", got, acc & 32'h55555500);
    bus(1'b1, 12'h054, 32'h55555500);
    bus(1'b0, 12'h054, 32'h0);
    check("pending all cleared", got, 32'h0);
    check("irq pair cleared", {31'h0, irq}, 32'h0);
    $display("interrupt test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 12'h044, 32'h0);
    check("data port after reset", got, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule
